// ---- dv/ims_host_model.sv ----
// host controller model issuing register accesses
`timescale 1ns/1ps
`default_nettype none

module ims_host_model
	import ims_pkg::*;
(
	input wire logic clk,
	output var ims_reg_req_t regReq
);
	initial regReq = '0;

	// one access every two cycles keeps each request whole and alone
	task automatic access(input logic r, input logic [6:0] a,
		input logic [15:0] d);
		@(posedge clk);
		#1;
		regReq = '{rd: r, wr: !r, addr: a, wdata: d};
		@(posedge clk);
		#1;
		regReq = '0;
	endtask

	// two requests on consecutive edges, which the port accepts
	task automatic accessPair(input ims_reg_req_t first,
		input ims_reg_req_t second);
		@(posedge clk);
		#1;
		regReq = first;
		@(posedge clk);
		#1;
		regReq = second;
		@(posedge clk);
		#1;
		regReq = '0;
	endtask
endmodule

`default_nettype wire

// ---- dv/ims_output_regs_monitor.sv ----
// checker for the output data register page ports
`timescale 1ns/1ps
`default_nettype none

module ims_output_regs_monitor
	import ims_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire ims_reg_req_t regReq,
	input wire logic sampleTick,
	input wire logic dataReady,
	input wire ims_reg_rsp_t regRsp
);
	logic [15:0] pageSel_ff;

	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// shadow of the selector so that reads of it can be predicted
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			pageSel_ff <= 16'h0000;
		else if (regReq.wr && regReq.addr == 7'h00)
			pageSel_ff <= regReq.wdata;

	sequence s_selWr;
		regReq.wr && regReq.addr == 7'h00;
	endsequence
	sequence s_selRd;
		regReq.rd && !regReq.wr && regReq.addr == 7'h00;
	endsequence

	property p_answer;
		regReq.rd |=> regRsp.valid;
	endproperty
	property p_quiet;
		!regReq.rd |=> !regRsp.valid;
	endproperty
	property p_hold;
		!regRsp.valid |-> $stable(regRsp.rdata);
	endproperty
	property p_odd;
		regReq.rd && regReq.addr[0] |=> regRsp.rdata == 16'h0000;
	endproperty
	property p_unmap;
		regReq.rd && regReq.addr == 7'h02 |=> regRsp.rdata == 16'h0000;
	endproperty
	property p_page;
		regReq.rd && regReq.addr == 7'h00 |=> regRsp.rdata == $past(pageSel_ff);
	endproperty
	property p_selBack;
		s_selWr ##1 s_selRd |=> regRsp.rdata == $past(regReq.wdata, 2);
	endproperty
	property p_ready;
		dataReady |-> $past(sampleTick);
	endproperty

	a_answer: assert property (p_answer) else $error("read not answered");
	a_quiet: assert property (p_quiet) else $error("answer without read");
	a_hold: assert property (p_hold) else $error("read data moved");
	a_odd: assert property (p_odd) else $error("odd address not zero");
	a_unmap: assert property (p_unmap) else $error("unmapped not zero");
	a_page: assert property (p_page) else $error("selector value wrong");
	a_selBack: assert property (p_selBack) else $error("selector readback");
	a_ready: assert property (p_ready) else $error("ready without sample");
endmodule

`default_nettype wire

// ---- dv/tb_inertial_output_data_regs.sv ----
// self-checking bench for the output data register page
`timescale 1ns/1ps
`default_nettype none

module tb_inertial_output_data_regs
	import ims_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic extSampleTick = 1'b0;
	ims_axes_t rateIn = '0;
	ims_axes_t accelIn = '0;
	ims_reg_req_t regReq;
	logic sampleTick;
	logic dataReady;
	ims_reg_rsp_t regRsp;
	logic [15:0] lfsr = 16'ha38c;
	logic [15:0] expQ[$];
	logic [15:0] expV;
	int miscompares = 0;
	int checks_done = 0;
	ims_axes_t a;
	ims_axes_t b;
	ims_meas_t [5:0] all;
	ims_meas_t m;
	longint acc;
	int sinceRdy = 0;
	int gap = 0;

	ims_output_regs DUT(.clk, .rst_n, .extSampleTick, .rateIn, .accelIn,
		.regReq, .sampleTick, .dataReady, .regRsp);
	ims_host_model host(.clk, .regReq);

	always #50 clk = ~clk;

	// small signed values keep the delta product inside 64 bits
	function automatic ims_meas_t rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		rnd = $signed({lfsr, lfsr[7:0], lfsr[15:8]}) >>> 4;
	endfunction

	task finish_test();
		if (expQ.size() != 0)
			miscompares++;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task chk(input logic [6:0] ad, input logic [15:0] e);
		expQ.push_back(e);
		host.access(1'b1, ad, 16'h0000);
	endtask

	task wr(input logic [6:0] ad, input logic [15:0] d);
		host.access(1'b0, ad, d);
	endtask

	task tick(input ims_axes_t r);
		@(posedge clk);
		#1;
		rateIn = r;
		accelIn = {rnd(), rnd(), rnd()};
		extSampleTick = 1'b1;
		@(posedge clk);
		#1;
		extSampleTick = 1'b0;
	endtask

	task waitRdy(input int n);
		int i;
		for (i = 0; i < n && dataReady !== 1'b1; i++)
			@(negedge clk);
		if (dataReady !== 1'b1)
		begin
			miscompares++;
			finish_test();
		end
	endtask

	always @(negedge clk)
		if (regRsp.valid === 1'b1)
		begin
			expV = (expQ.size() != 0) ? expQ.pop_front() : 16'hxxxx;
			checks_done++;
			if (regRsp.rdata !== expV)
			begin
				miscompares++;
				$display("FAIL t=%0t got %h exp %h", $time, regRsp.rdata, expV);
			end
		end

	// cycles between data ready pulses, to time the internal sample clock
	always @(posedge clk)
		if (dataReady === 1'b1)
		begin
			gap <= sinceRdy;
			sinceRdy <= 1;
		end
		else
			sinceRdy <= sinceRdy + 1;

	initial
	begin
		repeat (4) @(posedge clk);
		#1;
		rst_n = 1'b1;
		repeat (3) @(posedge clk);
		chk(7'h00, 16'h0000);
		chk(7'h02, 16'h0000);
		chk(7'h11, 16'h0000);
		// selector write and its readback on back-to-back edges
		expQ.push_back(PAGE_CTRL);
		host.accessPair('{rd: 1'b0, wr: 1'b1, addr: OFS_PAGE_SELECTOR,
			wdata: PAGE_CTRL}, '{rd: 1'b1, wr: 1'b0,
			addr: OFS_PAGE_SELECTOR, wdata: 16'h0000});
		wr(OFS_DECIMATION, 16'h0001);
		wr(OFS_SAMPLE_CTRL, 16'h0001);
		chk(OFS_DECIMATION, 16'h0001);
		chk(7'h00, PAGE_CTRL);
		wr(7'h00, PAGE_DATA);
		a = {rnd(), rnd(), rnd()};
		b = {rnd(), rnd(), rnd()};
		tick(a);
		tick(b);
		waitRdy(10);
		wr(OFS_RATE_X_UPPER, 16'h1234);
		all = {accelIn, b};
		for (int i = 0; i < 6; i++)
		begin
			chk(7'(7'h10 + 4 * i), all[i][15:0]);
			chk(7'(7'h12 + 4 * i), all[i][31:16]);
		end
		acc = longint'(a.axis[0]) * 2 + longint'(b.axis[0]);
		m = 32'((acc * longint'(INT_SCALE)) >>> SCALE_FRAC);
		chk(OFS_ANGLE_STEP_X_LOWER, m[15:0]);
		chk(7'h42, m[31:16]);
		wr(7'h00, PAGE_CTRL);
		wr(OFS_DECIMATION, 16'h0000);
		wr(OFS_SAMPLE_CTRL, 16'h0000);
		wr(7'h00, PAGE_DATA);
		rateIn = a;
		waitRdy(5000);
		acc = longint'(a.axis[0]) + longint'(b.axis[0]);
		m = 32'((acc * longint'(INT_SCALE)) >>> SCALE_FRAC);
		chk(7'h42, m[31:16]);
		chk(OFS_RATE_X_UPPER, a.axis[0][31:16]);
		// a stray external pulse must not count while internal is chosen
		@(posedge clk);
		#1;
		extSampleTick = 1'b1;
		@(posedge clk);
		#1;
		extSampleTick = 1'b0;
		waitRdy(5000);
		@(posedge clk);
		#1;
		checks_done++;
		if (gap != INT_TICK_CYCLES)
		begin
			miscompares++;
			$display("FAIL t=%0t got %h exp %h", $time, gap,
				INT_TICK_CYCLES);
		end
		// rate held at a, so the pair sum is twice a
		acc = 2 * longint'(a.axis[0]);
		m = 32'((acc * longint'(INT_SCALE)) >>> SCALE_FRAC);
		chk(OFS_ANGLE_STEP_X_LOWER, m[15:0]);
		chk(7'h42, m[31:16]);
		repeat (2) @(posedge clk);
		finish_test();
	end
endmodule

bind ims_output_regs ims_output_regs_monitor mon(.clk, .rst_n, .regReq,
	.sampleTick, .dataReady, .regRsp);

`default_nettype wire

// ---- verilog/ims_output_regs.sv ----
// output data register page: rate, acceleration and delta angle words
`timescale 1ns/1ps
`default_nettype none

module ims_output_regs
	import ims_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic extSampleTick,
	input wire ims_axes_t rateIn,
	input wire ims_axes_t accelIn,
	input wire ims_reg_req_t regReq,
	output logic sampleTick,
	output logic dataReady,
	output ims_reg_rsp_t regRsp
);

	// 49 bits hold up to 65536 pair sums of 33 bits
	localparam int ACC_W = MEAS_W + 1 + WORD_W;
	localparam int PROD_W = ACC_W + MEAS_W + 1;

	logic [1:0] rstSync_ff;
	logic rstN;

	logic [11:0] divCnt_ff;
	logic intTick;

	logic [15:0] pageSel_ff;
	logic [15:0] decimation_ff;
	ims_src_t srcSel_ff;
	logic [31:0] extScale_ff;
	logic [31:0] scale;

	logic [15:0] decCnt_ff;
	logic lastSample;

	ims_meas_t rate_ff [3];
	ims_meas_t accel_ff [3];
	ims_meas_t angleStep_ff [3];
	ims_meas_t prevRate_ff [3];
	logic signed [ACC_W-1:0] angleAcc_ff [3];
	logic signed [ACC_W-1:0] nxt_angleSum [3];
	logic signed [PROD_W-1:0] angleProd [3];

	logic dataReady_ff;
	ims_reg_rsp_t regRsp_ff;
	logic [15:0] nxt_rdata;

	// upper or lower half of a 32-bit value, chosen by address bit 1
	function automatic logic [15:0] wordOf(input ims_meas_t val,
		input logic [6:0] addr);
		logic [15:0] w;
		if (addr[1])
		begin
			w = val[31:16];
		end
		else
		begin
			w = val[15:0];
		end
		return w;
	endfunction

	// axis index within a group of three lower/upper pairs
	function automatic logic [1:0] axisOf(input logic [6:0] addr,
		input logic [6:0] base);
		logic [6:0] diff;
		diff = addr - base;
		return diff[3:2];
	endfunction

	// reset release through two flip-flops
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rstSync_ff <= 2'h0;
		end
		else
		begin
			rstSync_ff <= {rstSync_ff[0], 1'b1};
		end
	end
	assign rstN = rstSync_ff[1];

	// internal sample clock as a one-cycle enable
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			divCnt_ff <= 12'h000;
		end
		else if (divCnt_ff == INT_TICK_LAST)
		begin
			divCnt_ff <= 12'h000;
		end
		else
		begin
			divCnt_ff <= divCnt_ff + 12'h001;
		end
	end
	assign intTick = (divCnt_ff == INT_TICK_LAST);

	// external clock rate is the host's duty; the sums hold a full window at any rate
	assign sampleTick = (srcSel_ff == IMS_SRC_EXTERNAL) ?
		extSampleTick : intTick;
	assign scale = (srcSel_ff == IMS_SRC_EXTERNAL) ?
		extScale_ff : INT_SCALE;

	// page selector, written from any page
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			pageSel_ff <= RST_PAGE_SELECTOR;
		end
		else if (regReq.wr && regReq.addr == OFS_PAGE_SELECTOR)
		begin
			pageSel_ff <= regReq.wdata;
		end
	end

	// control page registers
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			decimation_ff <= RST_DECIMATION;
			srcSel_ff <= IMS_SRC_INTERNAL;
			extScale_ff <= INT_SCALE;
		end
		else if (regReq.wr && pageSel_ff == PAGE_CTRL)
		begin
			unique case (regReq.addr)
				OFS_DECIMATION:
				begin
					decimation_ff <= regReq.wdata;
				end
				OFS_SAMPLE_CTRL:
				begin
					srcSel_ff <= regReq.wdata[CTRL_EXT_CLK_BIT] ?
						IMS_SRC_EXTERNAL : IMS_SRC_INTERNAL;
				end
				OFS_EXT_SCALE_LOW:
				begin
					extScale_ff[15:0] <= regReq.wdata;
				end
				OFS_EXT_SCALE_HIGH:
				begin
					extScale_ff[31:16] <= regReq.wdata;
				end
				default:
				begin
					extScale_ff <= extScale_ff;
				end
			endcase
		end
	end

	// count samples within one integration window of D samples
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			decCnt_ff <= 16'h0000;
		end
		else if (sampleTick)
		begin
			if (lastSample)
			begin
				decCnt_ff <= 16'h0000;
			end
			else
			begin
				decCnt_ff <= decCnt_ff + 16'h0001;
			end
		end
	end
	// window ends when the count reaches the setting, so D = setting + 1
	assign lastSample = (decCnt_ff >= decimation_ff);

	genvar ax;
	generate
		for (ax = 0; ax < 3; ax++)
		begin : g_axis
			// pair of current and previous rate samples added to the window
			always_comb
			begin
				nxt_angleSum[ax] = angleAcc_ff[ax]
					+ ACC_W'(rateIn.axis[ax])
					+ ACC_W'(prevRate_ff[ax]);
			end

			// divide by 2 fs as a fixed-point product; bits 71:40 keep
			// 720/2^31 deg per lsb so the upper word is 720/2^15
			assign angleProd[ax] = nxt_angleSum[ax]
				* $signed({1'b0, scale});

			always_ff @(posedge clk or negedge rstN)
			begin
				if (!rstN)
				begin
					prevRate_ff[ax] <= '0;
					angleAcc_ff[ax] <= '0;
				end
				else if (sampleTick)
				begin
					prevRate_ff[ax] <= rateIn.axis[ax];
					if (lastSample)
					begin
						angleAcc_ff[ax] <= '0;
					end
					else
					begin
						angleAcc_ff[ax] <= nxt_angleSum[ax];
					end
				end
			end

			// all words of a window land in the same edge
			always_ff @(posedge clk or negedge rstN)
			begin
				if (!rstN)
				begin
					rate_ff[ax] <= '0;
					accel_ff[ax] <= '0;
					angleStep_ff[ax] <= '0;
				end
				else if (sampleTick && lastSample)
				begin
					// front end delivers rate in 0.02/2^16 deg/s steps
					rate_ff[ax] <= rateIn.axis[ax];
					// acceleration passes through with gravity kept
					accel_ff[ax] <= accelIn.axis[ax];
					angleStep_ff[ax] <= angleProd[ax][SCALE_FRAC +: MEAS_W];
				end
			end
		end
	endgenerate

	// new output set, one cycle after the window closes
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			dataReady_ff <= 1'b0;
		end
		else
		begin
			dataReady_ff <= sampleTick && lastSample;
		end
	end
	assign dataReady = dataReady_ff;

	// read decode; a measurement value is split only here, never stored in halves
	always_comb
	begin
		nxt_rdata = 16'h0000;
		if (regReq.addr == OFS_PAGE_SELECTOR)
		begin
			nxt_rdata = pageSel_ff;
		end
		else if (pageSel_ff == PAGE_DATA)
		begin
			if (regReq.addr >= OFS_RATE_X_LOWER &&
				regReq.addr <= OFS_RATE_Z_UPPER &&
				!regReq.addr[0])
			begin
				nxt_rdata = wordOf(rate_ff[axisOf(regReq.addr,
					OFS_RATE_X_LOWER)], regReq.addr);
			end
			else if (regReq.addr >= OFS_ACCEL_X_LOWER &&
				regReq.addr <= OFS_ACCEL_Z_UPPER &&
				!regReq.addr[0])
			begin
				nxt_rdata = wordOf(accel_ff[axisOf(regReq.addr,
					OFS_ACCEL_X_LOWER)], regReq.addr);
			end
			else if (regReq.addr >= OFS_ANGLE_STEP_X_LOWER &&
				regReq.addr <= OFS_ANGLE_STEP_Z_UPPER &&
				!regReq.addr[0])
			begin
				nxt_rdata = wordOf(angleStep_ff[axisOf(regReq.addr,
					OFS_ANGLE_STEP_X_LOWER)], regReq.addr);
			end
		end
		else if (pageSel_ff == PAGE_CTRL)
		begin
			unique case (regReq.addr)
				OFS_DECIMATION:
				begin
					nxt_rdata = decimation_ff;
				end
				OFS_SAMPLE_CTRL:
				begin
					nxt_rdata = {15'h0000, srcSel_ff == IMS_SRC_EXTERNAL};
				end
				OFS_EXT_SCALE_LOW:
				begin
					nxt_rdata = extScale_ff[15:0];
				end
				OFS_EXT_SCALE_HIGH:
				begin
					nxt_rdata = extScale_ff[31:16];
				end
				default:
				begin
					nxt_rdata = 16'h0000;
				end
			endcase
		end
	end

	// read answer one cycle after the request; upper words stand alone
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			regRsp_ff <= '0;
		end
		else
		begin
			regRsp_ff.valid <= regReq.rd;
			if (regReq.rd)
			begin
				regRsp_ff.rdata <= nxt_rdata;
			end
		end
	end
	assign regRsp = regRsp_ff;

endmodule

`default_nettype wire

// ---- verilog/ims_pkg.sv ----
// shared constants and types for the inertial output data register page
package ims_pkg;

	// system clock and internal sample clock
	localparam int CLK_HZ = 10000000;
	localparam int INT_SPS = 2460;
	// longest whole number of clock cycles per internal sample period
	localparam int INT_TICK_CYCLES = CLK_HZ / INT_SPS;
	localparam logic [11:0] INT_TICK_LAST = 12'(INT_TICK_CYCLES - 1);

	// register word and address widths
	localparam int WORD_W = 16;
	localparam int MEAS_W = 32;
	localparam int ADDR_W = 7;

	// offsets present on every page
	localparam logic [6:0] OFS_PAGE_SELECTOR = 7'h00;
	// page 0: rate, acceleration and delta angle words, lower at +0 and upper at +2
	localparam logic [6:0] OFS_RATE_X_LOWER = 7'h10;
	localparam logic [6:0] OFS_RATE_X_UPPER = 7'h12;
	localparam logic [6:0] OFS_RATE_Y_LOWER = 7'h14;
	localparam logic [6:0] OFS_RATE_Y_UPPER = 7'h16;
	localparam logic [6:0] OFS_RATE_Z_LOWER = 7'h18;
	localparam logic [6:0] OFS_RATE_Z_UPPER = 7'h1a;
	localparam logic [6:0] OFS_ACCEL_X_LOWER = 7'h1c;
	localparam logic [6:0] OFS_ACCEL_X_UPPER = 7'h1e;
	localparam logic [6:0] OFS_ACCEL_Y_LOWER = 7'h20;
	localparam logic [6:0] OFS_ACCEL_Y_UPPER = 7'h22;
	localparam logic [6:0] OFS_ACCEL_Z_LOWER = 7'h24;
	localparam logic [6:0] OFS_ACCEL_Z_UPPER = 7'h26;
	localparam logic [6:0] OFS_ANGLE_STEP_X_LOWER = 7'h40;
	localparam logic [6:0] OFS_ANGLE_STEP_Z_UPPER = 7'h4a;
	// page 3: control
	localparam logic [6:0] OFS_DECIMATION = 7'h0c;
	localparam logic [6:0] OFS_SAMPLE_CTRL = 7'h60;
	localparam logic [6:0] OFS_EXT_SCALE_LOW = 7'h62;
	localparam logic [6:0] OFS_EXT_SCALE_HIGH = 7'h64;
	localparam int CTRL_EXT_CLK_BIT = 0;

	localparam logic [15:0] PAGE_DATA = 16'h0000;
	localparam logic [15:0] PAGE_CTRL = 16'h0003;

	// reset values
	localparam logic [15:0] RST_PAGE_SELECTOR = 16'h0000;
	localparam logic [15:0] RST_DECIMATION = 16'h0000;
	localparam logic [15:0] RST_SAMPLE_CTRL = 16'h0000;

	// delta angle scale: rate lsb 0.02/2^16 deg/s, angle lsb 720/2^31 deg
	// angle = sum * 2^15 / (72000 * fs); held as a fraction of 2^40
	localparam int SCALE_FRAC = 40;
	localparam longint SCALE_NUM = 64'sh0080_0000_0000_0000;
	localparam longint SCALE_DEN_PER_HZ = 64'sd72000;
	localparam logic [31:0] INT_SCALE =
		32'(SCALE_NUM / (SCALE_DEN_PER_HZ * INT_SPS));

	typedef logic signed [MEAS_W-1:0] ims_meas_t;

	typedef struct packed {
		ims_meas_t [2:0] axis;
	} ims_axes_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] wdata;
	} ims_reg_req_t;

	typedef struct packed {
		logic valid;
		logic [WORD_W-1:0] rdata;
	} ims_reg_rsp_t;

	typedef enum logic {
		IMS_SRC_INTERNAL,
		IMS_SRC_EXTERNAL
	} ims_src_t;

endpackage
